//--- hw/hncq_cmd_layer.sv
// Purpose: Host command layer for native queued FPDMA commands
// Assumes: Transport logic on the same clock; status_in is live device status
// Notes:   Queue entries are identified to the upper layer by slot index
// Function
// - Accepted queued read or write is appended to the queue, then idle.
// - Untagged command gets a free tag, SActive bit set, then idle.
// - Tagged command sent as Register FIS, marked issued, then idle.
// - If link not ready, defer FIS, keep command unissued, return idle.
// - Device interrupt: read status, clearing interrupt, save copy, go compare.
// - Compare SActive to saved copy; retire if completions, else error check.
// - Retire commands of newly cleared tags, update stored SActive copy.
// - Saved status error bit clear keeps queue; set enters queue reset.
// - Queue reset sends READ LOG EXT page 0x10 FIS, then cleanup poll.
// - Cleanup polls status until DRQ one and BSY zero, then sense fetch.
// - Sense fetch waits for PIO data completion, then error flush.
// - Flush retires failed command, frees tags, flushes or reissues rest.
// - Tag assignment only with an untagged command and a free tag.
// - Issue only with a tagged unissued command, BSY zero, no data phase.
// - Device interrupt in idle leads to interrupt handling.
`default_nettype none
module hncq_cmd_layer
  import hncq_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 ce,
  input  wire logic                 cmd_valid,
  input  wire hncq_cmd_s            cmd_in,
  output logic                      cmd_accept_q,
  output logic [TAG_W-1:0]          cmd_slot_q,
  input  wire logic                 tx_ready,
  output logic                      fis_valid_q,
  output hncq_fis_s                 fis_q,
  output logic                      sactive_set_q,
  output logic [NUM_SLOTS-1:0]      sactive_mask_q,
  input  wire logic [NUM_SLOTS-1:0] sactive_in,
  input  wire logic                 dev_irq,
  input  wire logic [7:0]           status_in,
  output logic                      status_rd_q,
  input  wire logic                 data_phase,
  input  wire logic                 sense_done,
  input  wire logic [TAG_W-1:0]     sense_tag,
  input  wire logic                 reissue_en,
  output logic                      retire_valid_q,
  output logic [NUM_SLOTS-1:0]      retire_mask_q,
  output hncq_ret_e                 retire_kind_q,
  output logic [NUM_SLOTS-1:0]      retire_fail_q,
  output logic [7:0]                saved_status_q,
  output hncq_state_e               state_q
);
  hncq_state_e          state_d;
  logic [NUM_SLOTS-1:0] ent_valid_q, ent_valid_d;
  logic [NUM_SLOTS-1:0] ent_tagged_q, ent_tagged_d;
  logic [NUM_SLOTS-1:0] ent_issued_q, ent_issued_d;
  logic [TAG_W-1:0]     ent_tag_q [NUM_SLOTS];
  logic [TAG_W-1:0]     ent_tag_d [NUM_SLOTS];
  hncq_cmd_s            ent_cmd_q [NUM_SLOTS];
  hncq_cmd_s            ent_cmd_d [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] tag_used_q, tag_used_d;
  logic [NUM_SLOTS-1:0] sact_prev_q, sact_prev_d;
  logic [7:0]           saved_status_d;
  logic                 cmd_accept_d, fis_valid_d, sactive_set_d, status_rd_d;
  logic                 retire_valid_d;
  logic [TAG_W-1:0]     cmd_slot_d;
  hncq_fis_s            fis_d;
  logic [NUM_SLOTS-1:0] sactive_mask_d, retire_mask_d, retire_fail_d;
  hncq_ret_e            retire_kind_d;
  hncq_cmd_s            held_cmd_q, held_cmd_d;

  logic                 free_ent_ok, untag_ok, free_tag_ok, issue_ok;
  logic [TAG_W-1:0]     free_ent, untag_ent, free_tag, issue_ent;
  logic [NUM_SLOTS-1:0] done_tags;
  logic                 bsy, drq;

  hncq_first_one u_free_ent (.vec(~ent_valid_q), .found(free_ent_ok), .idx(free_ent));
  hncq_first_one u_untag (.vec(ent_valid_q & ~ent_tagged_q), .found(untag_ok),
                          .idx(untag_ent));
  hncq_first_one u_free_tag (.vec(~tag_used_q), .found(free_tag_ok), .idx(free_tag));
  hncq_first_one u_issue (.vec(ent_valid_q & ent_tagged_q & ~ent_issued_q),
                          .found(issue_ok), .idx(issue_ent));

  assign bsy       = status_in[BSY_BIT];
  assign drq       = status_in[DRQ_BIT];
  assign done_tags = sact_prev_q & ~sactive_in;

  always_comb begin
    state_d        = state_q;
    ent_valid_d    = ent_valid_q;
    ent_tagged_d   = ent_tagged_q;
    ent_issued_d   = ent_issued_q;
    ent_tag_d      = ent_tag_q;
    ent_cmd_d      = ent_cmd_q;
    tag_used_d     = tag_used_q;
    sact_prev_d    = sact_prev_q;
    saved_status_d = saved_status_q;
    held_cmd_d     = held_cmd_q;
    cmd_accept_d   = 1'b0;
    cmd_slot_d     = cmd_slot_q;
    fis_valid_d    = 1'b0;
    fis_d          = fis_q;
    sactive_set_d  = 1'b0;
    sactive_mask_d = sactive_mask_q;
    status_rd_d    = 1'b0;
    retire_valid_d = 1'b0;
    retire_mask_d  = retire_mask_q;
    retire_kind_d  = retire_kind_q;
    retire_fail_d  = retire_fail_q;
    unique case (state_q)
      IDLE_ST: begin
        if (dev_irq) begin
          state_d = INTERRUPT_ST;
        end else if (issue_ok && !bsy && !data_phase) begin
          state_d = ISSUE_ST;
        end else if (untag_ok && free_tag_ok) begin
          state_d = TAG_ASSIGN_ST;
        end else if (cmd_valid && free_ent_ok) begin
          held_cmd_d   = cmd_in;
          cmd_accept_d = 1'b1;
          cmd_slot_d   = free_ent;
          state_d      = ENQUEUE_ST;
        end
      end
      ENQUEUE_ST: begin
        ent_valid_d[cmd_slot_q]  = 1'b1;
        ent_tagged_d[cmd_slot_q] = 1'b0;
        ent_issued_d[cmd_slot_q] = 1'b0;
        ent_cmd_d[cmd_slot_q]    = held_cmd_q;
        state_d                  = IDLE_ST;
      end
      TAG_ASSIGN_ST: begin
        ent_tagged_d[untag_ent] = 1'b1;
        ent_tag_d[untag_ent]    = free_tag;
        tag_used_d[free_tag]    = 1'b1;
        sact_prev_d[free_tag]   = 1'b1;
        sactive_set_d           = 1'b1;
        sactive_mask_d          = MASK_RST;
        sactive_mask_d[free_tag] = 1'b1;
        state_d                 = IDLE_ST;
      end
      ISSUE_ST: begin
        if (tx_ready) begin
          fis_valid_d             = 1'b1;
          fis_d.opcode            = ent_cmd_q[issue_ent].wr ? OP_WR_FPDMA : OP_RD_FPDMA;
          fis_d.tag               = ent_tag_q[issue_ent];
          fis_d.lba               = ent_cmd_q[issue_ent].lba;
          fis_d.cnt               = ent_cmd_q[issue_ent].cnt;
          ent_issued_d[issue_ent] = 1'b1;
        end
        state_d = IDLE_ST;
      end
      INTERRUPT_ST: begin
        status_rd_d    = 1'b1;
        saved_status_d = status_in;
        state_d        = COMPARE_ST;
      end
      COMPARE_ST: begin
        state_d = (|done_tags) ? RETIRE_ST : ERR_CHECK_ST;
      end
      RETIRE_ST: begin
        retire_mask_d = MASK_RST;
        for (int i = 0; i < NUM_SLOTS; i++) begin
          if (ent_valid_q[i] && ent_tagged_q[i] && done_tags[ent_tag_q[i]]) begin
            retire_mask_d[i] = 1'b1;
            ent_valid_d[i]   = 1'b0;
          end
        end
        retire_valid_d = 1'b1;
        retire_kind_d  = RET_OK;
        retire_fail_d  = MASK_RST;
        tag_used_d     = tag_used_q & ~done_tags;
        sact_prev_d    = sactive_in;
        state_d        = ERR_CHECK_ST;
      end
      ERR_CHECK_ST: begin
        state_d = saved_status_q[ERR_BIT] ? Q_RESET_ST : IDLE_ST;
      end
      Q_RESET_ST: begin
        if (tx_ready) begin
          fis_valid_d  = 1'b1;
          fis_d.opcode = OP_RD_LOG;
          fis_d.tag    = '0;
          fis_d.lba    = LOG_PAGE;
          fis_d.cnt    = LOG_COUNT;
          state_d      = CLEAN_POLL_ST;
        end
      end
      CLEAN_POLL_ST: begin
        if (drq && !bsy) begin
          state_d = SENSE_ST;
        end
      end
      SENSE_ST: begin
        if (sense_done) begin
          saved_status_d = status_in;
          cmd_slot_d     = sense_tag;
          state_d        = ERR_FLUSH_ST;
        end
      end
      ERR_FLUSH_ST: begin
        retire_mask_d = MASK_RST;
        retire_fail_d = MASK_RST;
        for (int i = 0; i < NUM_SLOTS; i++) begin
          if (ent_valid_q[i] && ent_tagged_q[i] && ent_tag_q[i] == cmd_slot_q) begin
            retire_fail_d[i] = 1'b1;
            ent_valid_d[i]   = 1'b0;
          end else if (ent_valid_q[i] && !reissue_en) begin
            retire_mask_d[i] = 1'b1;
            ent_valid_d[i]   = 1'b0;
          end
        end
        ent_tagged_d   = MASK_RST;
        ent_issued_d   = MASK_RST;
        tag_used_d     = MASK_RST;
        sact_prev_d    = MASK_RST;
        retire_valid_d = 1'b1;
        retire_kind_d  = RET_SYS_ERR;
        state_d        = IDLE_ST;
      end
      default: begin
        state_d = IDLE_ST;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q        <= IDLE_ST;
      ent_valid_q    <= MASK_RST;
      ent_tagged_q   <= MASK_RST;
      ent_issued_q   <= MASK_RST;
      tag_used_q     <= MASK_RST;
      sact_prev_q    <= MASK_RST;
      saved_status_q <= STATUS_RST;
      held_cmd_q     <= '0;
      cmd_accept_q   <= 1'b0;
      cmd_slot_q     <= '0;
      fis_valid_q    <= 1'b0;
      fis_q          <= '0;
      sactive_set_q  <= 1'b0;
      sactive_mask_q <= MASK_RST;
      status_rd_q    <= 1'b0;
      retire_valid_q <= 1'b0;
      retire_mask_q  <= MASK_RST;
      retire_kind_q  <= RET_OK;
      retire_fail_q  <= MASK_RST;
      for (int i = 0; i < NUM_SLOTS; i++) begin
        ent_tag_q[i] <= '0;
        ent_cmd_q[i] <= '0;
      end
    end else if (ce) begin
      state_q        <= state_d;
      ent_valid_q    <= ent_valid_d;
      ent_tagged_q   <= ent_tagged_d;
      ent_issued_q   <= ent_issued_d;
      tag_used_q     <= tag_used_d;
      sact_prev_q    <= sact_prev_d;
      saved_status_q <= saved_status_d;
      held_cmd_q     <= held_cmd_d;
      cmd_accept_q   <= cmd_accept_d;
      cmd_slot_q     <= cmd_slot_d;
      fis_valid_q    <= fis_valid_d;
      fis_q          <= fis_d;
      sactive_set_q  <= sactive_set_d;
      sactive_mask_q <= sactive_mask_d;
      status_rd_q    <= status_rd_d;
      retire_valid_q <= retire_valid_d;
      retire_mask_q  <= retire_mask_d;
      retire_kind_q  <= retire_kind_d;
      retire_fail_q  <= retire_fail_d;
      ent_tag_q      <= ent_tag_d;
      ent_cmd_q      <= ent_cmd_d;
    end
  end
endmodule : hncq_cmd_layer
`default_nettype wire

//--- hw/hncq_first_one.sv
// Purpose: Finds the lowest set bit of a slot vector
// Assumes: Purely combinational
// Notes:   Index is zero when nothing is found
`default_nettype none
module hncq_first_one
  import hncq_pkg::*;
(
  input  wire logic [NUM_SLOTS-1:0] vec,
  output logic                      found,
  output logic [TAG_W-1:0]          idx
);
  always_comb begin
    found = 1'b0;
    idx   = '0;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (vec[i]) begin
        found = 1'b1;
        idx   = TAG_W'(i);
      end
    end
  end
endmodule : hncq_first_one
`default_nettype wire

//--- hw/hncq_pkg.sv
// Purpose: Shared types and constants for the queued command host layer
// Assumes: 32 tag slots, one internal queue entry per slot
// Notes:   Status bit positions follow the ATA status register layout
`default_nettype none
package hncq_pkg;
  localparam int          NUM_SLOTS   = 32;
  localparam int          TAG_W       = 5;
  localparam int          ERR_BIT     = 0;
  localparam int          DRQ_BIT     = 3;
  localparam int          BSY_BIT     = 7;
  localparam logic [7:0]  OP_RD_FPDMA = 8'h60;
  localparam logic [7:0]  OP_WR_FPDMA = 8'h61;
  localparam logic [7:0]  OP_RD_LOG   = 8'h2F;
  localparam logic [47:0] LOG_PAGE    = 48'h0000_0000_0010;
  localparam logic [15:0] LOG_COUNT   = 16'h0001;
  localparam logic [7:0]  STATUS_RST  = 8'h00;
  localparam logic [31:0] MASK_RST    = 32'h0000_0000;

  typedef enum logic [3:0] {
    IDLE_ST      = 4'b0000,
    INTERRUPT_ST = 4'b0001,
    COMPARE_ST   = 4'b0011,
    RETIRE_ST    = 4'b0010,
    ERR_CHECK_ST = 4'b0110,
    Q_RESET_ST   = 4'b0111,
    CLEAN_POLL_ST= 4'b0101,
    SENSE_ST     = 4'b0100,
    ERR_FLUSH_ST = 4'b1100,
    ENQUEUE_ST   = 4'b1101,
    TAG_ASSIGN_ST= 4'b1111,
    ISSUE_ST     = 4'b1110
  } hncq_state_e;

  typedef enum logic [1:0] {
    RET_OK      = 2'b00,
    RET_DEV_ERR = 2'b01,
    RET_SYS_ERR = 2'b10
  } hncq_ret_e;

  typedef struct packed {
    logic        wr;
    logic [47:0] lba;
    logic [15:0] cnt;
  } hncq_cmd_s;

  typedef struct packed {
    logic [7:0]       opcode;
    logic [TAG_W-1:0] tag;
    logic [47:0]      lba;
    logic [15:0]      cnt;
  } hncq_fis_s;
endpackage : hncq_pkg
`default_nettype wire

//--- testbench/hncq_cmd_layer_bench.sv
// Purpose: Self-checking bench for the queued command host layer
// Assumes: ce held high
// Notes:   Tags and retires tracked at the falling edge
`default_nettype none
module hncq_cmd_layer_bench
  import hncq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, ce, cmd_valid, tx_gate, done_req, done_err, reissue_en;
  logic cmd_accept_q, tx_ready, fis_valid_q, sactive_set_q, dev_irq, status_rd_q;
  logic data_phase, sense_done, retire_valid_q;
  logic [TAG_W-1:0] cmd_slot_q, sense_tag, fail_tag, ft;
  logic [31:0]      sactive_mask_q, sactive_in, retire_mask_q, retire_fail_q;
  logic [31:0]      done_mask, tags, t0, rem, r_mask, r_fail;
  logic [7:0]       status_in, saved_status_q, r_stat;
  hncq_cmd_s        cmd_in;
  hncq_fis_s        fis_q;
  hncq_ret_e        retire_kind_q, r_kind;
  hncq_state_e      state_q;
  int               fail_count, checks_done, cycles, fis_cnt, log_cnt, ret_cnt;
  hncq_cmd_layer dut_u (.clk, .srst, .ce, .cmd_valid, .cmd_in, .cmd_accept_q, .cmd_slot_q,
    .tx_ready, .fis_valid_q, .fis_q, .sactive_set_q, .sactive_mask_q, .sactive_in,
    .dev_irq, .status_in, .status_rd_q, .data_phase, .sense_done, .sense_tag,
    .reissue_en, .retire_valid_q, .retire_mask_q, .retire_kind_q, .retire_fail_q,
    .saved_status_q, .state_q);
  hncq_dev_model dev_u (.clk, .srst, .tx_gate, .done_req, .done_mask, .done_err,
    .fail_tag, .sactive_set_q, .sactive_mask_q, .status_rd_q, .fis_valid_q, .fis_q,
    .tx_ready, .dev_irq, .status_in, .sactive_in, .data_phase, .sense_done, .sense_tag);
  task automatic stop_test;
    $display("Checks made %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic send_cmd(input logic [47:0] a, input logic [TAG_W-1:0] s);
    int n;
    n = 0;
    cmd_in <= '{wr: a[0], lba: a, cnt: 16'h0008};
    cmd_valid <= 1'b1;
    while (cmd_accept_q !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("accepted", 32'(n < 100), 32'h0000_0001);
    chk("slot", 32'(cmd_slot_q), 32'(s));
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (40) @(posedge clk);
  endtask : send_cmd
  task automatic irq(input logic [31:0] m, input logic e, input int n);
    int k;
    k = 0;
    done_mask <= m;
    done_err <= e;
    done_req <= 1'b1;
    @(posedge clk);
    done_req <= 1'b0;
    while (ret_cnt < n && k < 200) begin
      @(posedge clk);
      k++;
    end
    repeat (20) @(posedge clk);
  endtask : irq
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      stop_test();
    end
  end
  always @(negedge clk) begin
    if (sactive_set_q === 1'b1) begin
      chk("tag_fresh", sactive_mask_q & tags, 32'h0000_0000);
      tags = tags | sactive_mask_q;
    end
    if (fis_valid_q === 1'b1 && fis_q.opcode === OP_RD_LOG) begin
      log_cnt++;
      chk("log_page", fis_q.lba[31:0], LOG_PAGE[31:0]);
    end else if (fis_valid_q === 1'b1) begin
      fis_cnt++;
      chk("fis_op", 32'(fis_q.opcode), fis_q.lba[0] ? 32'(OP_WR_FPDMA) : 32'(OP_RD_FPDMA));
      chk("fis_tag", 32'(tags[fis_q.tag]), 32'h0000_0001);
    end
    if (status_rd_q === 1'b1) r_stat = saved_status_q;
    if (retire_valid_q === 1'b1) begin
      ret_cnt++;
      r_mask = retire_mask_q;
      r_kind = retire_kind_q;
      r_fail = retire_fail_q;
      if (retire_kind_q === RET_SYS_ERR) tags = '0;
    end
  end
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    cmd_valid = 1'b0;
    cmd_in = '0;
    tx_gate = 1'b0;
    done_req = 1'b0;
    done_mask = '0;
    done_err = 1'b0;
    fail_tag = '0;
    reissue_en = 1'b0;
    tags = '0;
    repeat (16) @(negedge clk);
    chk("state_rst", 32'(state_q), 32'(IDLE_ST));
    chk("saved_rst", 32'(saved_status_q), 32'(STATUS_RST));
    chk("mask_rst", sactive_mask_q, MASK_RST);
    @(posedge clk);
    srst <= 1'b0;
    send_cmd(48'h0000_0000_0002, 5'h0);
    chk("deferred", fis_cnt, 0);
    t0 = tags;
    tx_gate <= 1'b1;
    repeat (20) @(posedge clk);
    chk("issued", fis_cnt, 1);
    send_cmd(48'h0000_0000_0003, 5'h1);
    send_cmd(48'h0000_0000_0004, 5'h2);
    chk("issued_all", fis_cnt, 3);
    irq(t0, 1'b0, 1);
    chk("ret_mask", r_mask, t0);
    chk("ret_kind", 32'(r_kind), 32'(RET_OK));
    irq(32'h0000_0000, 1'b0, 2);
    chk("no_retire", ret_cnt, 1);
    rem = tags & ~t0;
    ft = '0;
    for (int i = 0; i < NUM_SLOTS; i++) if (rem[i]) ft = i[TAG_W-1:0];
    fail_tag <= ft;
    irq(rem & (~rem + 32'h0000_0001), 1'b1, 3);
    chk("err_saved", 32'(r_stat[ERR_BIT]), 32'h0000_0001);
    chk("log_sent", log_cnt, 1);
    chk("flush_kind", 32'(r_kind), 32'(RET_SYS_ERR));
    chk("flush_fail", 32'($countones(r_fail)), 32'h0000_0001);
    chk("flush_idle", 32'(state_q), 32'(IDLE_ST));
    send_cmd(48'h0000_0000_0005, 5'h0);
    chk("reuse_tag", tags, 32'h0000_0001);
    send_cmd(48'h0000_0000_0006, 5'h1);
    fail_tag <= 5'h0;
    reissue_en <= 1'b1;
    irq(32'h0000_0000, 1'b1, 4);
    chk("keep_mask", r_mask, 32'h0000_0000);
    chk("fail_slot", r_fail, 32'h0000_0001);
    chk("log_again", log_cnt, 2);
    chk("reissued", fis_cnt, 6);
    chk("retag", tags, 32'h0000_0001);
    stop_test();
  end
endmodule : hncq_cmd_layer_bench
`default_nettype wire

//--- testbench/hncq_cmd_layer_monitor.sv
// Purpose: Port checks for the queued command host layer
// Assumes: ce held high
// Notes:   Attached by bind
`default_nettype none
module hncq_cmd_layer_monitor
  import hncq_pkg::*;
(
  input wire logic             clk,
  input wire logic             srst,
  input wire logic             dev_irq,
  input wire logic [7:0]       status_in,
  input wire logic             data_phase,
  input wire logic             tx_ready,
  input wire logic             sense_done,
  input wire logic             status_rd_q,
  input wire logic [7:0]       saved_status_q,
  input wire hncq_state_e      state_q,
  input wire logic             cmd_accept_q,
  input wire logic             sactive_set_q,
  input wire logic [31:0]      sactive_mask_q,
  input wire logic             fis_valid_q,
  input wire hncq_fis_s        fis_q,
  input wire logic             retire_valid_q,
  input wire hncq_ret_e        retire_kind_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_irq_walk;
    state_q == INTERRUPT_ST ##1 (status_rd_q && state_q == COMPARE_ST);
  endsequence
  sequence s_flush_walk;
    state_q == ERR_FLUSH_ST ##[0:1] retire_valid_q;
  endsequence
  a_irq_first: assert property (state_q == IDLE_ST && dev_irq |=> s_irq_walk)
    else $error("interrupt not served first");
  a_status_copy: assert property (status_rd_q |-> saved_status_q == $past(status_in))
    else $error("saved status wrong");
  a_retire_step: assert property (state_q == RETIRE_ST |=>
    retire_valid_q && retire_kind_q == RET_OK && state_q == ERR_CHECK_ST)
    else $error("retire step wrong");
  a_err_branch: assert property (state_q == ERR_CHECK_ST |=>
    state_q == ($past(saved_status_q[ERR_BIT]) ? Q_RESET_ST : IDLE_ST))
    else $error("error branch wrong");
  a_log_fis: assert property (state_q == Q_RESET_ST && tx_ready |=>
    fis_valid_q && fis_q.opcode == OP_RD_LOG && fis_q.lba == LOG_PAGE
    && state_q == CLEAN_POLL_ST)
    else $error("log fetch wrong");
  a_poll_exit: assert property (state_q == CLEAN_POLL_ST |=> state_q ==
    (($past(status_in[DRQ_BIT]) && !$past(status_in[BSY_BIT])) ? SENSE_ST : CLEAN_POLL_ST))
    else $error("poll exit wrong");
  a_sense_flush: assert property (state_q == SENSE_ST && sense_done |=> s_flush_walk)
    else $error("flush missing");
  a_tag_onehot: assert property (sactive_set_q |->
    $onehot(sactive_mask_q) && $past(state_q) == TAG_ASSIGN_ST)
    else $error("tag set wrong");
  a_issue_gate: assert property (state_q == ISSUE_ST |-> $past(state_q) == IDLE_ST
    && !$past(status_in[BSY_BIT]) && !$past(data_phase))
    else $error("issue gate wrong");
  a_fis_ready: assert property (fis_valid_q && fis_q.opcode != OP_RD_LOG |->
    $past(state_q) == ISSUE_ST && $past(tx_ready))
    else $error("fis without ready");
  a_accept_walk: assert property (cmd_accept_q |->
    state_q == ENQUEUE_ST ##1 state_q == IDLE_ST)
    else $error("enqueue walk wrong");
endmodule : hncq_cmd_layer_monitor
bind hncq_cmd_layer hncq_cmd_layer_monitor mon_u (.clk, .srst, .dev_irq, .status_in,
  .data_phase, .tx_ready, .sense_done, .status_rd_q, .saved_status_q, .state_q,
  .cmd_accept_q, .sactive_set_q, .sactive_mask_q, .fis_valid_q, .fis_q,
  .retire_valid_q, .retire_kind_q);
`default_nettype wire

//--- testbench/hncq_dev_model.sv
// Purpose: Far-side device model for the queued command host layer
// Assumes: Same clock; bench commands completions
// Notes:   Sense fetch shows busy, then data ready, then done
`default_nettype none
module hncq_dev_model
  import hncq_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             tx_gate,
  input  wire logic             done_req,
  input  wire logic [31:0]      done_mask,
  input  wire logic             done_err,
  input  wire logic [TAG_W-1:0] fail_tag,
  input  wire logic             sactive_set_q,
  input  wire logic [31:0]      sactive_mask_q,
  input  wire logic             status_rd_q,
  input  wire logic             fis_valid_q,
  input  wire hncq_fis_s        fis_q,
  output logic                  tx_ready,
  output logic                  dev_irq,
  output logic [7:0]            status_in,
  output logic [31:0]           sactive_in,
  output logic                  data_phase,
  output logic                  sense_done,
  output logic [TAG_W-1:0]      sense_tag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic [1:0] dp_q;
  assign tx_ready   = tx_gate;
  assign sense_tag  = fail_tag;
  assign data_phase = dp_q != 2'b00;
  always_ff @(posedge clk) begin
    if (srst) begin
      sactive_in <= 32'h0000_0000;
      dev_irq <= 1'b0;
      status_in <= 8'h00;
      sense_done <= 1'b0;
      cnt_q <= 4'h0;
      dp_q <= 2'b00;
    end else begin
      sense_done <= 1'b0;
      if (dp_q != 2'b00) dp_q <= dp_q - 2'b01;
      if (sactive_set_q) sactive_in <= sactive_in | sactive_mask_q;
      if (done_req) begin
        sactive_in <= sactive_in & ~done_mask;
        status_in[ERR_BIT] <= done_err;
        dev_irq <= 1'b1;
      end
      if (status_rd_q) dev_irq <= 1'b0;
      if (fis_valid_q && fis_q.opcode == OP_RD_LOG) cnt_q <= 4'h1;
      else if (fis_valid_q) dp_q <= 2'b11;
      if (cnt_q != 4'h0) cnt_q <= cnt_q + 4'h1;
      if (cnt_q == 4'h1) status_in[BSY_BIT] <= 1'b1;
      if (cnt_q == 4'h5) begin
        status_in <= 8'h00;
        status_in[DRQ_BIT] <= 1'b1;
      end
      if (cnt_q == 4'h9) begin
        status_in <= 8'h00;
        sactive_in <= 32'h0000_0000;
        sense_done <= 1'b1;
        cnt_q <= 4'h0;
      end
    end
  end
endmodule : hncq_dev_model
`default_nettype wire
